// File: fppic_burst_addr.sv
// Purpose: read address sequencer, linear or wrapped inside an aligned burst
// Assumes: load and step are single-cycle pulses from the same clock
// Notes:   load wins over step in the same cycle
`timescale 1ns/1ps
`default_nettype none

module fppic_burst_addr
	import fppic_pkg::*;
(
	input  wire logic  clock_in,
	input  wire logic  rst_in,
	fppic_burst_if.gen bus
);

	fppic_addr_s r;
	fppic_addr_s n;
	logic [6:0]        blk;
	logic [ADDR_W-1:0] mask;
	logic [ADDR_W-1:0] inc;

	////////////////////////////////////////////////////////////////////////////////
	// a wrapped burst is 8 << size bytes, always inside one 256-byte page
	always_comb
	begin
		n    = r;
		blk  = 7'((WRAP_MIN_BYTES << bus.burst_size) - 7'h01);
		mask = {{(ADDR_W-7){1'b0}}, blk};
		inc  = ADDR_W'(r.addr + 1'b1);
		if (bus.load)
			n.addr = bus.start_addr;
		else if (bus.step && bus.wrap_en)
			n.addr = (r.addr & ~mask) | (inc & mask);
		else if (bus.step)
			n.addr = inc;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			r <= '0;
		else
			r <= n;
	end

	assign bus.addr = r.addr;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	a_wrap_in_block: assert property (bus.step && bus.wrap_en && !bus.load |=>
		r.addr[ADDR_W-1:6] == $past(r.addr[ADDR_W-1:6])) else $error("wrap left block");
	a_linear_step: assert property (bus.step && !bus.wrap_en && !bus.load |=>
		r.addr == ADDR_W'($past(r.addr) + 1'b1)) else $error("linear step wrong");

endmodule // fppic_burst_addr

`default_nettype wire

// File: fppic_burst_if.sv
// Purpose: carrier between the command block and its burst address generator
// Assumes: single clock domain
// Notes:   ctl side steers, gen side owns the address
`timescale 1ns/1ps
`default_nettype none

interface fppic_burst_if;
	import fppic_pkg::*;
	logic                  load;
	logic                  step;
	logic [ADDR_W-1:0]     start_addr;
	logic                  wrap_en;
	logic [1:0]            burst_size;
	logic [ADDR_W-1:0]     addr;
	modport gen (input load, step, start_addr, wrap_en, burst_size, output addr);
	modport ctl (output load, step, start_addr, wrap_en, burst_size, input addr);
endinterface

`default_nettype wire

// File: fppic_cmd.sv
// Purpose: power-down, read parameter, extended register and legacy id commands of a serial flash
// Assumes: link pins sampled by the 50 MHz clock; array engine logic on the same clock
// Notes:   rules of behaviour below
//
// Notes on behaviour
// - power-down entry only after whole opcode, then cs rise
// - powered down: only release opcode recognised
// - normal operation resumes after release delay
// - release/id ignored while write in progress
// - wrap bits 2:0, dummy cycle count 6:3
// - bit 7 picks hold or reset function
// - non-volatile parameter write needs write enable latch
// - volatile write: one opcode needs latch, one not
// - wrap values 4..7 give 8..64 bytes
// - wrapped burst stays in aligned block
// - unwrapped reads count straight through array
// - wrap persists until cleared, power-down, reset
// - drive strength set volatile or non-volatile
// - parameter readback returns volatile copy
// - extended readback works during write
// - error flags sticky until clear opcode
// - id after three dummy bytes, repeated
// - power-down accepted in single and quad mode
// - write in progress while self-timed work runs
// - reset reloads volatile from non-volatile
`timescale 1ns/1ps
`default_nettype none

module fppic_cmd
	import fppic_pkg::*;
#(
	parameter int         PD_ENTRY_CYC        = PD_ENTRY_CYCLES,
	parameter int         PD_RELEASE_CYC      = PD_RELEASE_CYCLES,
	parameter int         NV_WRITE_CYC        = NV_WRITE_CYCLES,
	parameter logic [7:0] DEVICE_ID           = 8'h5A,  // arbitrary value
	parameter logic       DEDICATED_RESET_PIN = 1'b0
)
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              sck_in,
	input  wire logic              cs_n_in,
	input  wire logic [3:0]        io_in,
	output var  logic [3:0]        io_out,
	output var  logic [3:0]        io_oe_out,
	input  wire logic              qpi_mode_in,
	input  wire logic              op_busy_in,
	input  wire logic              protection_error_in,
	input  wire logic              program_error_in,
	input  wire logic              erase_error_in,
	input  wire logic              reset_req_in,
	input  wire logic              read_start_in,
	input  wire logic [ADDR_W-1:0] read_start_addr_in,
	input  wire logic              read_step_in,
	output var  logic [ADDR_W-1:0] read_addr_out,
	output var  logic              powered_down_out,
	output var  logic              write_enable_latch_out,
	output var  logic              write_in_progress_out,
	output var  logic              wrap_enable_out,
	output var  logic [1:0]        burst_size_out,
	output var  logic [3:0]        dummy_cycle_count_out,
	output var  logic              hold_reset_select_out,
	output var  logic              pin_reset_mode_out,
	output var  logic [2:0]        drive_strength_out,
	output var  logic [2:0]        error_flags_out
);

	fppic_cmd_s r;
	fppic_cmd_s n;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       cs_high;
	logic [5:0] step;
	logic [2:0] out_step;
	logic [7:0] ext_reg;

	fppic_burst_if burst ();

	////////////////////////////////////////////////////////////////////////////////
	// edges from the second and third sync stages only
	assign sck_rise = r.sck_sync[1] & ~r.sck_sync[2];
	assign sck_fall = ~r.sck_sync[1] & r.sck_sync[2];
	assign cs_rise  = r.cs_sync[1] & ~r.cs_sync[2];
	assign cs_high  = r.cs_sync[1];
	// quad mode moves four bits per clock, both for commands and answers
	assign step     = qpi_mode_in ? STEP_QPI : STEP_SPI;
	assign out_step = qpi_mode_in ? 3'h4 : 3'h1;

	// extended read register as software sees it
	always_comb
	begin
		ext_reg                    = 8'h00;
		ext_reg[EXT_DS_HI:EXT_DS_LO] = r.ds_vol;
		ext_reg[EXT_ERASE_ERR_BIT] = r.err[2];
		ext_reg[EXT_PROG_ERR_BIT]  = r.err[1];
		ext_reg[EXT_PROT_ERR_BIT]  = r.err[0];
		ext_reg[EXT_WIP_BIT]       = r.write_in_progress;
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		n = r;
		n.sck_sync = {r.sck_sync[1:0], sck_in};
		n.cs_sync  = {r.cs_sync[1:0], cs_n_in};
		n.io_sync0 = io_in;
		n.io_sync1 = r.io_sync0;

		// self-timed non-volatile write keeps the busy flag up
		n.write_in_progress = op_busy_in | (r.nvcnt != 20'h0);
		if (r.nvcnt != 20'h0)
			n.nvcnt = r.nvcnt - 20'h1;

		// power-down sequencing; delays are cycle parameters
		case (r.pd)
			PD_ENTER:
			begin
				if (r.cnt == 20'h0)
				begin
					n.pd     = PD_DOWN;
					n.rp_vol = r.rp_nv;  // wrap setting ends with power-down
				end
				else
					n.cnt = r.cnt - 20'h1;
			end
			PD_RELEASE:
			begin
				// nothing is taken until the count ends
				if (r.cnt == 20'h0)
					n.pd = PD_NORMAL;
				else
					n.cnt = r.cnt - 20'h1;
			end
			default:
			begin
			end
		endcase

		// serial input on rising link clock, answers on falling
		if (cs_high)
		begin
			n.in_cnt     = 6'h00;
			n.out_active = 1'b0;
			n.io_oe      = 4'h0;
		end
		else if (sck_rise && r.in_cnt < BITS_SAT)
		begin
			if (qpi_mode_in)
				n.shift = {r.shift[3:0], r.io_sync1};
			else
				n.shift = {r.shift[6:0], r.io_sync1[0]};
			n.in_cnt = 6'(r.in_cnt + step);
			if (n.in_cnt == BITS_OPCODE)
			begin
				n.opcode = n.shift;
				// readbacks only in normal operation
				if (r.pd == PD_NORMAL && n.shift == PARAM_READBACK_CMD)
				begin
					n.out_active = 1'b1;
					n.out_byte   = r.rp_vol;  // volatile copy only
					n.out_idx    = 3'h7;
				end
				else if (r.pd == PD_NORMAL && n.shift == EXT_PARAM_READBACK_CMD)
				begin
					n.out_active = 1'b1;
					n.out_byte   = ext_reg;  // allowed while busy
					n.out_idx    = 3'h7;
				end
			end
			if (n.in_cnt == BITS_DATA)
				n.data = n.shift;
			// legacy id after three dummy bytes, not while busy
			if (n.in_cnt == BITS_ID_DUMMY && r.opcode == POWER_DOWN_RELEASE_CMD &&
			    r.pd == PD_NORMAL && !r.write_in_progress)
			begin
				n.out_active = 1'b1;
				n.out_byte   = DEVICE_ID;
				n.out_idx    = 3'h7;
			end
		end
		else if (sck_fall && r.out_active)
		begin
			// msb first; the index wraps so the byte repeats until cs rises
			if (qpi_mode_in)
			begin
				n.io_out = r.out_idx[2] ? r.out_byte[7:4] : r.out_byte[3:0];
				n.io_oe  = QPI_OUT_ENABLE;
			end
			else
			begin
				n.io_out = {2'b00, r.out_byte[r.out_idx], 1'b0};
				n.io_oe  = SPI_OUT_ENABLE;
			end
			n.out_idx = 3'(r.out_idx - out_step);
		end

		// commands act on the rising edge of chip select
		if (cs_rise && r.pd == PD_NORMAL)
		begin
			case (r.opcode)
				POWER_DOWN_ENTER_CMD:
				begin
					// only an exact opcode, in either line mode
					if (r.in_cnt == BITS_OPCODE)
					begin
						n.pd  = PD_ENTER;
						n.cnt = 20'(PD_ENTRY_CYC - 1);
					end
				end
				WRITE_ENABLE_CMD:
				begin
					if (r.in_cnt == BITS_OPCODE)
						n.write_enable_latch = 1'b1;
				end
				WRITE_DISABLE_CMD:
				begin
					if (r.in_cnt == BITS_OPCODE)
						n.write_enable_latch = 1'b0;
				end
				PARAM_WRITE_NONVOLATILE_CMD:
				begin
					// both copies, latch required, not over a running write
					if (r.in_cnt == BITS_DATA && r.write_enable_latch && !r.write_in_progress)
					begin
						n.rp_nv  = r.data;
						n.rp_vol = r.data;
						n.write_enable_latch    = 1'b0;
						n.nvcnt  = 20'(NV_WRITE_CYC);
					end
				end
				PARAM_WRITE_VOLATILE_CMD:
				begin
					if (r.in_cnt == BITS_DATA && r.write_enable_latch)
					begin
						n.rp_vol = r.data;
						n.write_enable_latch    = 1'b0;
					end
				end
				PARAM_WRITE_VOLATILE_FREE_CMD:
				begin
					// no latch needed and the latch is left alone
					if (r.in_cnt == BITS_DATA)
						n.rp_vol = r.data;
				end
				EXT_PARAM_WRITE_NONVOLATILE_CMD:
				begin
					if (r.in_cnt == BITS_DATA && r.write_enable_latch && !r.write_in_progress)
					begin
						n.ds_nv  = r.data[EXT_DS_HI:EXT_DS_LO];
						n.ds_vol = r.data[EXT_DS_HI:EXT_DS_LO];
						n.write_enable_latch    = 1'b0;
						n.nvcnt  = 20'(NV_WRITE_CYC);
					end
				end
				EXT_PARAM_WRITE_VOLATILE_CMD:
				begin
					if (r.in_cnt == BITS_DATA)
						n.ds_vol = r.data[EXT_DS_HI:EXT_DS_LO];
				end
				ERROR_FLAG_CLEAR_CMD:
				begin
					if (r.in_cnt == BITS_OPCODE)
						n.err = 3'h0;
				end
				default:
				begin
				end
			endcase
		end
		else if (cs_rise && r.pd == PD_DOWN)
		begin
			// everything but release is dropped; release is refused while the busy flag is up
			if (r.opcode == POWER_DOWN_RELEASE_CMD && r.in_cnt >= BITS_OPCODE &&
			    !r.write_in_progress)
			begin
				n.pd  = PD_RELEASE;
				n.cnt = 20'(PD_RELEASE_CYC - 1);  // host keeps cs high meanwhile
			end
		end

		// device reset reloads the working copies, including a write landing this cycle
		if (reset_req_in)
		begin
			n.rp_vol = n.rp_nv;
			n.ds_vol = n.ds_nv;
		end

		// a new error in the clearing cycle survives: set wins
		n.err = n.err | {erase_error_in, program_error_in, protection_error_in};

		// a separate reset pin ignores the select bit
		n.pin_reset_mode = ~DEDICATED_RESET_PIN & n.rp_vol[RP_HOLD_RESET_BIT];

		// the power-down output comes from its own flop, not from a state decode
		n.down = (n.pd == PD_DOWN);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; non-volatile copies start from their delivered values
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			r        <= '0;
			r.cs_sync <= 3'h7;  // idle chip select is high: no false rise after reset
			r.rp_nv  <= READ_PARAMETERS_RESET;
			r.rp_vol <= READ_PARAMETERS_RESET;
			r.ds_nv  <= DRIVE_STRENGTH_RESET;
			r.ds_vol <= DRIVE_STRENGTH_RESET;
		end
		else
			r <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// burst address generator steered by the wrap fields
	assign burst.load       = read_start_in;
	assign burst.step       = read_step_in;
	assign burst.start_addr = read_start_addr_in;
	assign burst.wrap_en    = r.rp_vol[RP_WRAP_BIT];
	assign burst.burst_size = r.rp_vol[RP_BURST_HI:RP_BURST_LO];

	fppic_burst_addr u_burst (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.bus      (burst.gen)
	);

	// outputs straight from flops
	assign io_out                 = r.io_out;
	assign io_oe_out              = r.io_oe;
	assign read_addr_out          = burst.addr;
	assign powered_down_out       = r.down;
	assign write_enable_latch_out = r.write_enable_latch;
	assign write_in_progress_out  = r.write_in_progress;
	assign wrap_enable_out        = r.rp_vol[RP_WRAP_BIT];
	assign burst_size_out         = r.rp_vol[RP_BURST_HI:RP_BURST_LO];
	assign dummy_cycle_count_out  = r.rp_vol[RP_DUMMY_HI:RP_DUMMY_LO];
	assign hold_reset_select_out  = r.rp_vol[RP_HOLD_RESET_BIT];
	assign pin_reset_mode_out     = r.pin_reset_mode;
	assign drive_strength_out     = r.ds_vol;
	assign error_flags_out        = r.err;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sequence s_enter_done;
		(r.pd == PD_ENTER) ##1 (r.pd == PD_DOWN);
	endsequence

	sequence s_release_start;
		(r.pd == PD_DOWN) ##1 (r.pd == PD_RELEASE);
	endsequence

	a_down_entry_path: assert property ($rose(r.pd == PD_ENTER) |->
		$past(cs_rise) && $past(r.opcode) == POWER_DOWN_ENTER_CMD &&
		$past(r.in_cnt) == BITS_OPCODE) else $error("power-down entered without full opcode");
	a_pd_wrap_reset: assert property (s_enter_done |-> r.rp_vol == r.rp_nv)
		else $error("wrap setting kept over power-down");
	a_down_frozen: assert property ((r.pd == PD_DOWN) ##1 (r.pd == PD_DOWN) |->
		$stable(r.write_enable_latch) && ($stable(r.ds_vol) || $past(reset_req_in)) && r.io_oe == 4'h0)
		else $error("command acted while powered down");
	a_release_timed: assert property ((r.pd == PD_NORMAL) && $past(r.pd) == PD_RELEASE |->
		$past(r.cnt) == 20'h0) else $error("released before delay");
	a_release_no_wip: assert property (s_release_start |-> !$past(r.write_in_progress))
		else $error("release taken while busy");
	a_nv_needs_wel: assert property ($changed(r.rp_nv) |-> $past(r.write_enable_latch) && !r.write_enable_latch &&
		r.rp_vol == r.rp_nv) else $error("non-volatile write without latch");
	a_free_write_wel: assert property ($changed(r.rp_vol) && !$past(r.write_enable_latch) |-> !r.write_enable_latch)
		else $error("latch set by volatile write");
	a_param_readback: assert property ($rose(r.out_active) &&
		r.opcode == PARAM_READBACK_CMD |-> r.out_byte == $past(r.rp_vol))
		else $error("readback not volatile copy");
	a_ext_readback: assert property ($rose(r.out_active) &&
		r.opcode == EXT_PARAM_READBACK_CMD |-> r.out_byte == $past(ext_reg))
		else $error("extended readback wrong");
	a_errors_sticky: assert property ($fell(r.err[0]) |->
		$past(cs_rise) && $past(r.opcode) == ERROR_FLAG_CLEAR_CMD)
		else $error("error flag dropped without clear");
	a_wip_follows: assert property (op_busy_in |=> r.write_in_progress)
		else $error("busy flag missing");
	a_id_after_dummy: assert property ($rose(r.out_active) &&
		r.opcode == POWER_DOWN_RELEASE_CMD |-> r.in_cnt == BITS_ID_DUMMY &&
		r.out_byte == DEVICE_ID) else $error("id answer misplaced");

endmodule // fppic_cmd

`default_nettype wire

// File: fppic_host.sv
// Purpose: host model that frames commands on the serial link
// Assumes: link clock of eight block clocks, parked low between frames
// Notes:   lines it does not drive carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module fppic_host
(
	input  wire logic       clock_in,
	output var  logic       sck_out,
	output var  logic       cs_n_out,
	output var  logic [3:0] io_out,
	input  wire logic [3:0] dev_io_in
);
	////////////////////////////////////////////////////////////////////////////////
	// idle link at time zero
	initial
	begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		io_out = 4'h0;
	end

	// nb bits sent w lines at a time, then nr bits read from line 1
	task automatic frame(input int nb, input int w, input logic [39:0] tx, input int nr,
		output logic [15:0] rd);
		rd = 16'h0;
		@(negedge clock_in);
		cs_n_out = 1'b0;
		for (int i = 0; i < nb / w + nr; i++)
		begin
			if (i < nb / w)
				io_out = (w == 4) ? tx[39:36] : {~io_out[3:1], tx[39]};
			else
				io_out = ~io_out;  // no stale value while reading
			tx = tx << w;
			repeat (4) @(negedge clock_in);
			sck_out = 1'b1;  // bits latched on the rise
			repeat (4) @(negedge clock_in);
			if (i >= nb / w)
				rd = {rd[14:0], dev_io_in[1]};
			sck_out = 1'b0;
		end
		repeat (4) @(negedge clock_in);
		cs_n_out = 1'b1;  // raised after the whole frame
		io_out = ~io_out;
		repeat (6) @(negedge clock_in);
	endtask
endmodule // fppic_host

`default_nettype wire

// File: fppic_pkg.sv
// Purpose: shared constants, state types for the flash power, parameter and id command block
// Assumes: 50 MHz block clock, serial link sampled by that clock
// Notes:   timing counts are derived here; the top module re-exposes them as parameters
`default_nettype none

package fppic_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS         = 20;
	localparam int PD_ENTRY_DELAY_NS     = 3000;    // power_down_entry_delay
	localparam int PD_RELEASE_DELAY_NS   = 5000;    // power_down_release_delay
	localparam int NV_WRITE_TIME_NS      = 100000;  // self-timed non-volatile register write
	// longest times: round down; the two power-down counts never below one cycle
	localparam int PD_ENTRY_CYCLES       = (PD_ENTRY_DELAY_NS / CLK_PERIOD_NS > 0) ?
	                                       PD_ENTRY_DELAY_NS / CLK_PERIOD_NS : 1;
	localparam int PD_RELEASE_CYCLES     = (PD_RELEASE_DELAY_NS / CLK_PERIOD_NS > 0) ?
	                                       PD_RELEASE_DELAY_NS / CLK_PERIOD_NS : 1;
	localparam int NV_WRITE_CYCLES       = NV_WRITE_TIME_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// command opcodes
	localparam logic [7:0] POWER_DOWN_ENTER_CMD            = 8'hB9;
	localparam logic [7:0] POWER_DOWN_RELEASE_CMD          = 8'hAB;  // also legacy_id_read_cmd
	localparam logic [7:0] WRITE_ENABLE_CMD                = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD               = 8'h04;
	localparam logic [7:0] PARAM_WRITE_NONVOLATILE_CMD     = 8'h65;
	localparam logic [7:0] PARAM_WRITE_VOLATILE_CMD        = 8'h63;
	localparam logic [7:0] PARAM_WRITE_VOLATILE_FREE_CMD   = 8'hC0;
	localparam logic [7:0] EXT_PARAM_WRITE_NONVOLATILE_CMD = 8'h85;
	localparam logic [7:0] EXT_PARAM_WRITE_VOLATILE_CMD    = 8'h83;
	localparam logic [7:0] PARAM_READBACK_CMD              = 8'h61;
	localparam logic [7:0] EXT_PARAM_READBACK_CMD          = 8'h81;
	localparam logic [7:0] ERROR_FLAG_CLEAR_CMD            = 8'h82;

	////////////////////////////////////////////////////////////////////////////////
	// bit counts on the link, counted in data bits
	localparam logic [5:0] BITS_OPCODE   = 6'h08;
	localparam logic [5:0] BITS_DATA     = 6'h10;
	localparam logic [5:0] BITS_ID_DUMMY = 6'h20;
	localparam logic [5:0] BITS_SAT      = 6'h28;
	localparam logic [5:0] STEP_SPI      = 6'h01;
	localparam logic [5:0] STEP_QPI      = 6'h04;

	////////////////////////////////////////////////////////////////////////////////
	// read_parameters fields
	localparam int RP_HOLD_RESET_BIT = 7;
	localparam int RP_DUMMY_HI       = 6;
	localparam int RP_DUMMY_LO       = 3;
	localparam int RP_WRAP_BIT       = 2;
	localparam int RP_BURST_HI       = 1;
	localparam int RP_BURST_LO       = 0;
	localparam logic [7:0] READ_PARAMETERS_RESET = 8'h00;

	// extended read register fields
	localparam int EXT_DS_HI         = 7;
	localparam int EXT_DS_LO         = 5;
	localparam int EXT_ERASE_ERR_BIT = 3;
	localparam int EXT_PROG_ERR_BIT  = 2;
	localparam int EXT_PROT_ERR_BIT  = 1;
	localparam int EXT_WIP_BIT       = 0;
	localparam logic [2:0] DRIVE_STRENGTH_RESET = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// link lines and addressing
	localparam logic [3:0] SPI_OUT_ENABLE = 4'h2;  // single line: output on line 1
	localparam logic [3:0] QPI_OUT_ENABLE = 4'hF;
	localparam int         ADDR_W         = 26;
	localparam logic [6:0] WRAP_MIN_BYTES = 7'h08;

	typedef enum logic [1:0] {PD_NORMAL, PD_ENTER, PD_DOWN, PD_RELEASE} fppic_pd_e;

	typedef struct packed {
		logic [2:0] sck_sync;
		logic [2:0] cs_sync;
		logic [3:0] io_sync0;
		logic [3:0] io_sync1;
		fppic_pd_e  pd;
		logic [19:0] cnt;
		logic [19:0] nvcnt;
		logic        write_in_progress;
		logic        write_enable_latch;
		logic [7:0]  shift;
		logic [5:0]  in_cnt;
		logic [7:0]  opcode;
		logic [7:0]  data;
		logic        out_active;
		logic [7:0]  out_byte;
		logic [2:0]  out_idx;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic [7:0]  rp_vol;
		logic [7:0]  rp_nv;
		logic [2:0]  ds_vol;
		logic [2:0]  ds_nv;
		logic [2:0]  err;        // {erase, program, protection}
		logic        pin_reset_mode;
		logic        down;       // registered copy of the powered-down state
	} fppic_cmd_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
	} fppic_addr_s;

endpackage

`default_nettype wire

// File: tb_fppic_cmd.sv
// Purpose: self-checking bench for fppic_cmd
// Assumes: host model drives the link, inputs change on falling clock edges
// Notes:   delays shortened by parameters so the run stays brief
`timescale 1ns/1ps
`default_nettype none

module tb_fppic_cmd;
	import fppic_pkg::*;
	logic              clock_in, rst_in, qpi, busy, perr, rreq, rstart, rstep;
	logic              sck, cs_n, pd, write_enable_latch, write_in_progress, wrap, hold, pinrst;
	logic [3:0]        io_h, io_d, dum, oe;
	logic [1:0]        bsz;
	logic [2:0]        ds, ef;
	logic [ADDR_W-1:0] saddr, raddr;
	logic [15:0]       rd;
	int                error_cnt, checks_done;

	fppic_cmd #(.PD_ENTRY_CYC(10), .PD_RELEASE_CYC(10), .NV_WRITE_CYC(200)) DUT (
		.clock_in(clock_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .io_in(io_h),
		.io_out(io_d), .io_oe_out(oe), .qpi_mode_in(qpi), .op_busy_in(busy),
		.protection_error_in(perr), .program_error_in(perr), .erase_error_in(perr),
		.reset_req_in(rreq), .read_start_in(rstart), .read_start_addr_in(saddr),
		.read_step_in(rstep), .read_addr_out(raddr), .powered_down_out(pd),
		.write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress), .wrap_enable_out(wrap),
		.burst_size_out(bsz), .dummy_cycle_count_out(dum), .hold_reset_select_out(hold),
		.pin_reset_mode_out(pinrst), .drive_strength_out(ds), .error_flags_out(ef));
	fppic_host host (.clock_in(clock_in), .sck_out(sck), .cs_n_out(cs_n), .io_out(io_h),
		.dev_io_in(io_d));

	////////////////////////////////////////////////////////////////////////////////
	// 50 MHz clock
	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// single-line command with optional data byte and readback bits
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb, input int nr);
		host.frame(nb, 1, {op, d, 24'h0}, nr, rd);
	endtask

	task automatic rb(input logic [7:0] op, input logic [15:0] e);
		cmd(op, 8'h00, 8, 8);
		chk("readback", e, rd);
	endtask

	// one address step pulse, then let the update land
	task automatic step();
		rstep = 1'b1;
		@(negedge clock_in);
		rstep = 1'b0;
		@(negedge clock_in);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog: the sequence needs well under 20k clocks
	initial
	begin
		repeat (60000) @(posedge clock_in);
		error_cnt++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial
	begin
		{rst_in, qpi, busy, perr, rreq, rstart, rstep} = 7'h40;
		saddr = '0;
		error_cnt = 0;
		checks_done = 0;
		repeat (5) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (5) @(negedge clock_in);
		rb(8'h61, 16'h0000);
		rb(8'h81, 16'h00E0);
		$display("test reset done");
		cmd(8'hC0, 8'hA6, 16, 0);
		chk("fields", 16'h0299, {6'h0, hold, dum, wrap, bsz, write_enable_latch, pinrst});
		cmd(8'h63, 8'h00, 16, 0);  // refused: latch clear
		rb(8'h61, 16'h00A6);
		$display("test volatile done");
		cmd(8'h06, 8'h00, 8, 0);
		chk("latch", 1'b1, write_enable_latch);
		cmd(8'h65, 8'h05, 16, 0);
		chk("busy", 2'h2, {write_in_progress, write_enable_latch});
		rb(8'h81, 16'h00E1);
		for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++)
			@(negedge clock_in);
		rb(8'h61, 16'h0005);
		cmd(8'h83, 8'h40, 16, 0);
		chk("strength", 3'h2, ds);
		rb(8'h81, 16'h0040);
		$display("test nonvolatile done");
		saddr = 26'h00000FE;
		rstart = 1'b1;
		@(negedge clock_in);
		rstart = 1'b0;
		@(negedge clock_in);
		step();
		chk("addr", 16'h00FF, raddr[15:0]);
		step();
		chk("addr", 16'h00F0, raddr[15:0]);
		cmd(8'hC0, 8'h00, 16, 0);
		step();
		step();
		chk("addr", 16'h00F2, raddr[15:0]);
		$display("test burst done");
		// one pulse raises all three error inputs together
		perr = 1'b1;
		@(negedge clock_in);
		perr = 1'b0;
		repeat (30) @(negedge clock_in);
		chk("errors", 3'h7, ef);
		cmd(8'h82, 8'h00, 8, 0);
		chk("errors", 3'h0, ef);
		cmd(8'hAB, 8'h00, 32, 16);
		chk("id", 16'h5A5A, rd);
		chk("oe", 4'h0, oe);
		$display("test id done");
		cmd(8'hC0, 8'hA6, 16, 0);
		qpi = 1'b1;
		host.frame(8, 4, {8'hB9, 32'h0}, 0, rd);
		qpi = 1'b0;
		repeat (12) @(negedge clock_in);
		chk("down", 1'b1, pd);
		cmd(8'hC0, 8'hFF, 16, 0);  // ignored while down
		// a busy array must keep the release from being taken
		busy = 1'b1;
		cmd(8'hAB, 8'h00, 8, 0);
		chk("down", 1'b1, pd);
		busy = 1'b0;
		cmd(8'hAB, 8'h00, 8, 0);
		repeat (10) @(negedge clock_in);  // chip select kept high
		chk("down", 1'b0, pd);
		rb(8'h61, 16'h0005);
		cmd(8'hC0, 8'h00, 16, 0);
		rreq = 1'b1;
		@(negedge clock_in);
		rreq = 1'b0;
		rb(8'h61, 16'h0005);
		$display("test power done");
		stop_test();
	end
endmodule // tb_fppic_cmd

`default_nettype wire
